// ---- hw/tcu_map.svh ----
// Constants for the 8-bit timer counter compare unit
// Assumes inclusion by bare name from design files
//
// Functional notes
// - Flag top when count reaches maximum, bottom when count reaches zero
// - Clock source select zero stops the counter entirely
// - Software may read and write the count at any time
// - Software count write beats clear or count in the same cycle
// - Waveform mode select chooses up, clear or up-down counting
// - Overflow flag set per mode and cleared on service or writing one
// - Compare count with compare value continuously, match when equal
// - Compare flag set one timer tick after the match
// - Compare interrupt needs flag, enable bit and global enable
// - Compare flag cleared on interrupt service or writing one
// - Compare value double buffered in PWM modes only
// - Buffered compare value loaded only at top
// - Software compare access goes to buffer or active register by mode
// - Force strobe updates latch as a match, no flag, no counter change
// - Count write blocks compare match in next timer tick, even stopped
// - Compare output latch keeps value across mode changes
// - Output action not buffered; applies from first match after write
// - Reset clears the compare output latch to zero
// - Nonzero output action makes latch drive the pin
// - Pin direction stays under port direction bit during override
// - Output action zero leaves latch unchanged on match
// - Force strobe ignores zero and acts only in non-PWM modes
// - Normal mode counts up, wraps, overflow set when count becomes zero
// - Clear-on-match mode clears count when it matches compare value
// - Fast PWM counts zero to max; clear on match, set at bottom
// - Phase correct counts up and down; clear on up match, set on down
`ifndef TCU_MAP_SVH
`define TCU_MAP_SVH

`define TCU_MAX        8'hff
`define TCU_BOTTOM     8'h00
`define TCU_CNT_RESET  8'h00
`define TCU_CMP_RESET  8'h00
`define TCU_CS_STOP    3'h0
`define TCU_CS_EXT_FALL 3'h6
`define TCU_CS_EXT_RISE 3'h7

`endif

// ---- hw/tcu_pkg.sv ----
// Types for the 8-bit timer counter compare unit
// Assumes the map header supplies the numeric constants
package tcu_pkg;

    typedef enum logic [1:0] {
        TCU_WGM_NORMAL = 2'b00,
        TCU_WGM_PCPWM  = 2'b01,
        TCU_WGM_CTC    = 2'b10,
        TCU_WGM_FPWM   = 2'b11
    } tcu_wgm_e;

    typedef logic [7:0] tcu_byte_t;

endpackage

// ---- hw/tcu_cmp_if.sv ----
// Carrier between counter core and compare output unit
// Assumes one clock domain shared by both ends
`timescale 1ns/1ns
interface tcu_cmp_if;
    import tcu_pkg::*;
    logic     match_event;
    logic     force_event;
    logic     count_up;
    logic     at_bottom;
    logic     at_max;
    tcu_wgm_e mode;
    logic [1:0] action;
    logic     latch;

    modport core (output match_event, output force_event, output count_up,
                  output at_bottom, output at_max, output mode, output action,
                  input latch);
    modport wave (input match_event, input force_event, input count_up,
                  input at_bottom, input at_max, input mode, input action,
                  output latch);
endinterface

// ---- hw/tcu_wave.sv ----
// Compare output latch update logic
// Assumes events are one-cycle pulses on the system clock
`timescale 1ns/1ns
module tcu_wave (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic resetn_i,
    // Link to core
    tcu_cmp_if.wave   cmp
);
    import tcu_pkg::*;

    // ----------------------------------------
    // Latch update
    // ----------------------------------------
    logic next_latch;
    logic pwm;

    always_comb begin
        pwm        = (cmp.mode == TCU_WGM_PCPWM) || (cmp.mode == TCU_WGM_FPWM);
        next_latch = cmp.latch;
        if (!pwm) begin
            if (cmp.match_event || cmp.force_event) begin
                case (cmp.action)
                    2'b00:   next_latch = cmp.latch;
                    2'b01:   next_latch = ~cmp.latch;
                    2'b10:   next_latch = 1'b0;
                    2'b11:   next_latch = 1'b1;
                    default: next_latch = cmp.latch;
                endcase
            end
        end else if (cmp.mode == TCU_WGM_FPWM) begin
            if (cmp.action == 2'b01 && cmp.match_event) begin
                next_latch = ~cmp.latch;
            end else if (cmp.action[1]) begin
                if (cmp.match_event) begin
                    next_latch = cmp.action[0];
                end else if (cmp.at_bottom) begin
                    next_latch = ~cmp.action[0];
                end
            end
        end else begin
            if (cmp.action[1] && cmp.match_event) begin
                next_latch = cmp.count_up ? cmp.action[0] : ~cmp.action[0];
            end
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cmp.latch <= 1'b0;
        end else begin
            cmp.latch <= next_latch;
        end
    end

endmodule

// ---- hw/tcu_top.sv ----
// 8-bit up/down timer counter with one output compare channel
// Assumes prescaler ticks arrive from the same clock; ext pin is asynchronous
`timescale 1ns/1ns
`include "tcu_map.svh"
module tcu_top #(
    // Prescaler tick lines
    parameter int unsigned TICK_SOURCES = 8
) (
    // Clock and reset
    input  wire logic            clk_i,
    input  wire logic            resetn_i,
    // Tick sources
    input  wire logic [TICK_SOURCES-1:0] presc_tick_i,
    input  wire logic            ext_pin_i,
    // Control
    input  wire logic [2:0]      clock_source_select_i,
    input  wire tcu_pkg::tcu_wgm_e waveform_mode_select_i,
    input  wire logic [1:0]      compare_output_action_i,
    input  wire logic            compare_irq_enable_i,
    input  wire logic            cpu_status_word_gie_i,
    input  wire logic            force_compare_strobe_i,
    // Count access
    input  wire logic            count_value_we_i,
    input  wire logic [7:0]      count_value_wdata_i,
    output      logic [7:0]      count_value_o,
    // Compare access
    input  wire logic            compare_value_we_i,
    input  wire logic [7:0]      compare_value_wdata_i,
    output      logic [7:0]      compare_value_o,
    // Flags
    input  wire logic            flag_clear_we_i,
    input  wire logic            compare_flag_wdata_i,
    input  wire logic            overflow_flag_wdata_i,
    input  wire logic            compare_irq_ack_i,
    input  wire logic            overflow_irq_ack_i,
    output      logic            compare_flag_o,
    output      logic            overflow_flag_o,
    output      logic            compare_irq_o,
    // Counter status
    output      logic            top_o,
    output      logic            bottom_o,
    // Pin
    input  wire logic            port_data_i,
    input  wire logic            output_pin_direction_i,
    output      logic            pin_out_o,
    output      logic            pin_oe_o
);
    import tcu_pkg::*;

    // ----------------------------------------
    // Parameter check
    // ----------------------------------------
    // Tick select indexes prescaler lines 1 to 5 of the eight
    if (TICK_SOURCES != 8) begin : g_tick_check
        $error("tcu_top needs exactly eight prescaler tick lines");
    end

    // ----------------------------------------
    // External pin synchroniser and edge
    // ----------------------------------------
    logic ext_s1;
    logic ext_s2;
    logic ext_s3;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ext_s1 <= 1'b0;
            ext_s2 <= 1'b0;
            ext_s3 <= 1'b0;
        end else begin
            ext_s1 <= ext_pin_i;
            ext_s2 <= ext_s1;
            ext_s3 <= ext_s2;
        end
    end

    // ----------------------------------------
    // Timer tick select
    // ----------------------------------------
    logic timer_tick;

    always_comb begin
        case (clock_source_select_i)
            `TCU_CS_STOP:     timer_tick = 1'b0;
            `TCU_CS_EXT_FALL: timer_tick = ext_s3 & ~ext_s2;
            `TCU_CS_EXT_RISE: timer_tick = ~ext_s3 & ext_s2;
            default:          timer_tick = presc_tick_i[clock_source_select_i];
        endcase
    end

    // ----------------------------------------
    // Compare registers
    // ----------------------------------------
    tcu_cmp_if cmp ();

    logic [7:0] cmp_active;
    logic [7:0] cmp_buffer;
    logic       pwm_mode;
    logic       reload_point;
    logic [7:0] count;
    logic       count_up;

    assign pwm_mode = (waveform_mode_select_i == TCU_WGM_PCPWM)
                   || (waveform_mode_select_i == TCU_WGM_FPWM);

    // Load at max in both phase correct and fast PWM
    always_comb begin
        if (waveform_mode_select_i == TCU_WGM_PCPWM) begin
            reload_point = timer_tick && (count == `TCU_MAX);
        end else begin
            reload_point = timer_tick && (count == `TCU_MAX);
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cmp_buffer <= `TCU_CMP_RESET;
        end else if (compare_value_we_i) begin
            cmp_buffer <= compare_value_wdata_i;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cmp_active <= `TCU_CMP_RESET;
        end else if (!pwm_mode) begin
            if (compare_value_we_i) begin
                cmp_active <= compare_value_wdata_i;
            end else begin
                cmp_active <= cmp_buffer;
            end
        end else if (reload_point) begin
            cmp_active <= cmp_buffer;
        end
    end

    // ----------------------------------------
    // Match and blocking
    // ----------------------------------------
    logic raw_match;
    logic block_next;
    logic match_tick;

    assign raw_match  = (count == cmp_active);
    assign match_tick = timer_tick && raw_match && !block_next;

    // A count write blocks matches up to and including the next tick
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            block_next <= 1'b0;
        end else if (count_value_we_i) begin
            block_next <= 1'b1;
        end else if (timer_tick) begin
            block_next <= 1'b0;
        end
    end

    // ----------------------------------------
    // Counter
    // ----------------------------------------
    logic [7:0] next_count;
    logic       next_up;
    logic       ovf_event;

    always_comb begin
        next_count = count;
        next_up    = count_up;
        ovf_event  = 1'b0;
        if (timer_tick) begin
            case (waveform_mode_select_i)
                TCU_WGM_NORMAL: begin
                    next_count = count + 8'h01;
                    ovf_event  = (count == `TCU_MAX);
                end
                TCU_WGM_CTC: begin
                    if (raw_match && !block_next) begin
                        next_count = `TCU_BOTTOM;
                    end else begin
                        next_count = count + 8'h01;
                    end
                    ovf_event = (count == `TCU_MAX);
                end
                TCU_WGM_FPWM: begin
                    next_count = count + 8'h01;
                    ovf_event  = (count == `TCU_MAX);
                end
                TCU_WGM_PCPWM: begin
                    if (count_up && count == `TCU_MAX) begin
                        next_up    = 1'b0;
                        next_count = count - 8'h01;
                    end else if (!count_up && count == `TCU_BOTTOM) begin
                        next_up    = 1'b1;
                        next_count = count + 8'h01;
                    end else begin
                        next_count = count_up ? count + 8'h01 : count - 8'h01;
                    end
                    ovf_event = !count_up && (count == 8'h01);
                end
                default: next_count = count;
            endcase
        end
        if (count_value_we_i) begin
            next_count = count_value_wdata_i;
            ovf_event  = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            count    <= `TCU_CNT_RESET;
            count_up <= 1'b1;
        end else begin
            count    <= next_count;
            count_up <= next_up;
        end
    end

    // ----------------------------------------
    // Flags
    // ----------------------------------------
    logic cmp_pending;

    // Flag follows the match by one timer tick
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cmp_pending <= 1'b0;
        end else if (timer_tick) begin
            cmp_pending <= match_tick;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            compare_flag_o <= 1'b0;
        end else if (timer_tick && cmp_pending) begin
            compare_flag_o <= 1'b1;
        end else if (compare_irq_ack_i
                  || (flag_clear_we_i && compare_flag_wdata_i)) begin
            compare_flag_o <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            overflow_flag_o <= 1'b0;
        end else if (ovf_event) begin
            overflow_flag_o <= 1'b1;
        end else if (overflow_irq_ack_i
                  || (flag_clear_we_i && overflow_flag_wdata_i)) begin
            overflow_flag_o <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            compare_irq_o <= 1'b0;
        end else begin
            compare_irq_o <= compare_flag_o && compare_irq_enable_i
                          && cpu_status_word_gie_i
                          && !compare_irq_ack_i;
        end
    end

    // ----------------------------------------
    // Link to output unit
    // ----------------------------------------
    assign cmp.match_event = match_tick;
    assign cmp.force_event = force_compare_strobe_i && !pwm_mode;
    assign cmp.count_up    = count_up;
    assign cmp.at_bottom   = timer_tick && (count == `TCU_MAX);
    assign cmp.at_max      = (count == `TCU_MAX);
    assign cmp.mode        = waveform_mode_select_i;
    assign cmp.action      = compare_output_action_i;

    tcu_wave u_wave (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .cmp      (cmp)
    );

    // ----------------------------------------
    // Registered outputs
    // ----------------------------------------
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            count_value_o   <= `TCU_CNT_RESET;
            compare_value_o <= `TCU_CMP_RESET;
            top_o           <= 1'b0;
            bottom_o        <= 1'b0;
        end else begin
            count_value_o   <= next_count;
            compare_value_o <= pwm_mode ? cmp_buffer : cmp_active;
            top_o           <= (next_count == `TCU_MAX);
            bottom_o        <= (next_count == `TCU_BOTTOM);
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pin_out_o <= 1'b0;
            pin_oe_o  <= 1'b0;
        end else begin
            pin_oe_o  <= output_pin_direction_i;
            pin_out_o <= (|compare_output_action_i) ? cmp.latch
                                                    : port_data_i;
        end
    end

endmodule

// ---- verification/tcu_top_assertions.sv ----
// Concurrent checks on the timer counter compare unit ports
// Assumes binding onto tcu_top in a single clock domain
`timescale 1ns/1ns
module tcu_top_assertions (
    input wire logic       clk_i,
    input wire logic       resetn_i,
    input wire logic [2:0] clock_source_select_i,
    input wire logic [1:0] compare_output_action_i,
    input wire logic       compare_irq_enable_i,
    input wire logic       cpu_status_word_gie_i,
    input wire logic       force_compare_strobe_i,
    input wire logic       count_value_we_i,
    input wire logic [7:0] count_value_wdata_i,
    input wire logic       flag_clear_we_i,
    input wire logic       compare_flag_wdata_i,
    input wire logic       compare_irq_ack_i,
    input wire logic       port_data_i,
    input wire logic       output_pin_direction_i,
    input wire logic [7:0] count_value_o,
    input wire logic       compare_flag_o,
    input wire logic       overflow_flag_o,
    input wire logic       compare_irq_o,
    input wire logic       top_o,
    input wire logic       bottom_o,
    input wire logic       pin_out_o,
    input wire logic       pin_oe_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    // ----
    // Steps
    // ----
    sequence stopped_s;
        (clock_source_select_i == 3'h0) [*3];
    endsequence
    sequence settled_s;
        $past(resetn_i);
    endsequence
    chk_count_write:
    assert property (count_value_we_i |=> count_value_o == $past(count_value_wdata_i))
        else $error("count write not taken");
    chk_stop_hold:
    assert property (clock_source_select_i == 3'h0 && !count_value_we_i |=> $stable(count_value_o))
        else $error("count moved while stopped");
    chk_no_set_stopped:
    assert property (stopped_s |-> !$rose(compare_flag_o) && !$rose(overflow_flag_o))
        else $error("flag set while stopped");
    chk_bottom_flag:
    assert property (settled_s |-> bottom_o == (count_value_o == 8'h00))
        else $error("bottom indication wrong");
    chk_top_flag:
    assert property (settled_s |-> top_o == (count_value_o == 8'hff))
        else $error("top indication wrong");
    chk_irq_gate:
    assert property (settled_s |-> compare_irq_o ==
        $past(compare_flag_o && compare_irq_enable_i && cpu_status_word_gie_i
        && !compare_irq_ack_i))
        else $error("compare request gating wrong");
    chk_ack_clear:
    assert property (stopped_s ##0 compare_irq_ack_i |=> !compare_flag_o)
        else $error("service did not clear flag");
    chk_zero_keep:
    assert property (flag_clear_we_i && !compare_flag_wdata_i && !compare_irq_ack_i &&
        compare_flag_o |=> compare_flag_o) else $error("zero write cleared flag");
    chk_force_quiet:
    assert property (stopped_s ##0 force_compare_strobe_i && !compare_flag_o |=>
        !compare_flag_o && $stable(count_value_o)) else $error("force touched flag or count");
    chk_pin_dir:
    assert property (settled_s |-> pin_oe_o == $past(output_pin_direction_i))
        else $error("pin direction not followed");
    chk_pin_port:
    assert property (settled_s ##0 $past(compare_output_action_i) == 2'h0 |->
        pin_out_o == $past(port_data_i)) else $error("port value not on pin");
endmodule

bind tcu_top tcu_top_assertions chk_u (.clk_i, .resetn_i, .clock_source_select_i,
    .compare_output_action_i, .compare_irq_enable_i, .cpu_status_word_gie_i,
    .force_compare_strobe_i, .count_value_we_i, .count_value_wdata_i, .flag_clear_we_i,
    .compare_flag_wdata_i, .compare_irq_ack_i, .port_data_i, .output_pin_direction_i,
    .count_value_o, .compare_flag_o, .overflow_flag_o, .compare_irq_o, .top_o, .bottom_o,
    .pin_out_o, .pin_oe_o);

// ---- verification/tcu_top_tb.sv ----
// Self-checking bench for the timer counter compare unit
// Assumes tcu_top, its package and the checker are compiled first
`timescale 1ns/1ns
module tcu_top_tb;
    import tcu_pkg::*;
    logic       clk_i = 1'b0;
    logic       resetn_i = 1'b0;
    logic [7:0] presc_tick_i = 8'h00;
    logic       ext_pin_i = 1'b0;
    logic [2:0] clock_source_select_i = 3'h0;
    tcu_wgm_e   waveform_mode_select_i = TCU_WGM_NORMAL;
    logic [1:0] compare_output_action_i = 2'h1;
    logic       compare_irq_enable_i = 1'b1;
    logic       cpu_status_word_gie_i = 1'b0;
    logic [5:0] strobe = 6'h00;
    logic [7:0] count_value_wdata_i = 8'h00;
    logic [7:0] compare_value_wdata_i = 8'h00;
    logic       compare_flag_wdata_i = 1'b0;
    logic       overflow_flag_wdata_i = 1'b1;
    logic       port_data_i = 1'b1;
    logic       output_pin_direction_i = 1'b1;
    logic [7:0] count_value_o, compare_value_o;
    logic       compare_flag_o, overflow_flag_o, compare_irq_o;
    logic       top_o, bottom_o, pin_out_o, pin_oe_o;
    logic [1:0] act_code [3] = '{2'h3, 2'h2, 2'h1};
    logic [7:0] act_exp [3] = '{8'h01, 8'h00, 8'h01};
    int         failures = 0;
    int         checks_done = 0;

    always #10 clk_i = ~clk_i;

    tcu_top dut_u (
        .clk_i, .resetn_i, .presc_tick_i, .ext_pin_i, .clock_source_select_i,
        .waveform_mode_select_i, .compare_output_action_i, .compare_irq_enable_i,
        .cpu_status_word_gie_i, .force_compare_strobe_i(strobe[0]),
        .count_value_we_i(strobe[1]), .count_value_wdata_i, .count_value_o,
        .compare_value_we_i(strobe[2]), .compare_value_wdata_i, .compare_value_o,
        .flag_clear_we_i(strobe[3]), .compare_flag_wdata_i, .overflow_flag_wdata_i,
        .compare_irq_ack_i(strobe[4]), .overflow_irq_ack_i(strobe[5]), .compare_flag_o,
        .overflow_flag_o, .compare_irq_o, .top_o, .bottom_o, .port_data_i,
        .output_pin_direction_i, .pin_out_o, .pin_oe_o
    );

    // ----
    // Access tasks
    // ----
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        @(negedge clk_i);
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
        @(posedge clk_i);
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic pulse(input logic [5:0] m);
        @(posedge clk_i) strobe <= m;
        @(posedge clk_i) strobe <= 6'h00;
        step(2);
    endtask
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge clk_i) presc_tick_i <= 8'h02;
            @(posedge clk_i) presc_tick_i <= 8'h00;
            step(2);
        end
    endtask
    task automatic wrc(input logic [7:0] v);
        count_value_wdata_i <= v;
        pulse(6'h02);
    endtask
    task automatic wro(input logic [7:0] v);
        compare_value_wdata_i <= v;
        pulse(6'h04);
    endtask
    task automatic wrap_up();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ----
    // Tests
    // ----
    initial begin
        step(12);
        resetn_i <= 1'b1;
        step(2);
        chk("latch on pin", 8'h00, {7'h00, pin_out_o});
        wrc(8'h05);
        chk("count", 8'h05, count_value_o);
        ticks(1);
        chk("stopped count", 8'h05, count_value_o);
        clock_source_select_i <= 3'h1;
        wrc(8'hfe);
        ticks(1);
        chk("top", 8'h01, {7'h00, top_o});
        ticks(1);
        chk("wrap", 8'h00, count_value_o);
        chk("overflow", 8'h01, {7'h00, overflow_flag_o});
        pulse(6'h20);
        chk("overflow serviced", 8'h00, {7'h00, overflow_flag_o});
        wro(8'h10);
        chk("compare direct", 8'h10, compare_value_o);
        count_value_wdata_i <= 8'h80;
        @(posedge clk_i) begin
            presc_tick_i <= 8'h02;
            strobe <= 6'h02;
        end
        @(posedge clk_i) begin
            presc_tick_i <= 8'h00;
            strobe <= 6'h00;
        end
        step(2);
        chk("write beats tick", 8'h80, count_value_o);
        wrc(8'h0f);
        ticks(2);
        chk("flag at match", 8'h00, {7'h00, compare_flag_o});
        ticks(1);
        chk("flag after match", 8'h01, {7'h00, compare_flag_o});
        chk("irq global off", 8'h00, {7'h00, compare_irq_o});
        cpu_status_word_gie_i <= 1'b1;
        step(2);
        chk("irq on", 8'h01, {7'h00, compare_irq_o});
        compare_irq_enable_i <= 1'b0;
        step(2);
        chk("irq masked", 8'h00, {7'h00, compare_irq_o});
        pulse(6'h08);
        chk("zero write", 8'h01, {7'h00, compare_flag_o});
        compare_flag_wdata_i <= 1'b1;
        pulse(6'h08);
        chk("one write", 8'h00, {7'h00, compare_flag_o});
        clock_source_select_i <= 3'h0;
        wrc(8'h10);
        pulse(6'h10);
        clock_source_select_i <= 3'h1;
        ticks(2);
        chk("blocked match", 8'h00, {7'h00, compare_flag_o});
        clock_source_select_i <= 3'h0;
        step(2);
        foreach (act_code[i]) begin
            compare_output_action_i <= act_code[i];
            pulse(6'h01);
            chk("forced latch", act_exp[i], {7'h00, pin_out_o});
        end
        chk("force no flag", 8'h00, {7'h00, compare_flag_o});
        chk("force no count", 8'h12, count_value_o);
        compare_output_action_i <= 2'h0;
        port_data_i <= 1'b0;
        pulse(6'h01);
        chk("port on pin", 8'h00, {7'h00, pin_out_o});
        compare_output_action_i <= 2'h1;
        output_pin_direction_i <= 1'b0;
        step(2);
        chk("idle action", 8'h01, {7'h00, pin_out_o});
        chk("pin input", 8'h00, {7'h00, pin_oe_o});
        output_pin_direction_i <= 1'b1;
        waveform_mode_select_i <= TCU_WGM_FPWM;
        pulse(6'h01);
        chk("force in pwm", 8'h01, {7'h00, pin_out_o});
        compare_output_action_i <= 2'h0;
        clock_source_select_i <= 3'h1;
        wro(8'hfe);
        chk("compare buffer", 8'hfe, compare_value_o);
        wrc(8'hfd);
        ticks(3);
        chk("old compare", 8'h00, {7'h00, compare_flag_o});
        wrc(8'hfd);
        ticks(3);
        chk("reloaded compare", 8'h01, {7'h00, compare_flag_o});
        pulse(6'h08);
        waveform_mode_select_i <= TCU_WGM_CTC;
        wro(8'h10);
        wrc(8'h0e);
        ticks(3);
        chk("clear on match", 8'h00, count_value_o);
        waveform_mode_select_i <= TCU_WGM_PCPWM;
        wrc(8'hfe);
        ticks(2);
        chk("down count", 8'hfe, count_value_o);
        wrap_up();
    end

    initial begin
        step(6000);
        failures++;
        wrap_up();
    end
endmodule
